// ===== design/pmc_defs.vh
// constants and mode codes for the power mode controller
// Notes on behaviour
// R01: five modes: active, auto alternating, alternative active, sleep, hibernate.
// R02: auto alternating mode flips active/alt-active on slow and main oscillator ticks.
// R03: sleep and hibernate disable every subsystem regardless of templates.
// R04: subsystems marked unavailable stay off after waking from sleep or hibernate.
// R05: active template of 14 registers, one enable bit per subsystem.
// R06: in active mode firmware may change template bits any time.
// R07: cpu may disable itself through its template bit in active mode.
// R08: cpu enable not sticky; returning to active from lower mode enables cpu.
// R09: active entered on wakeup, reset, or writing 0 while in alternative active.
// R10: wakeup in alt-active, sleep or hibernate sets active and enables cpu.
// R11: after boot the mode is active.
// R12: writing a mode code in active mode moves to that lower mode.
// R13: firmware checks flash controller idle before writing mode select.
// R14: pending wakeup source prevents leaving active mode.
// R15: alternative active uses its own template bits.
// R16: any interrupt in alternative active returns to active.
// R17: in sleep the regulators are buzzed periodically.
// R18: in hibernate only the hibernate regulator stays on.
// R19: sleep and hibernate wakeup interrupts bypass edge detect logic.
// R20: sleep and hibernate requests ignored during first 1 ms after reset.
// R21: wakeup from sleep or hibernate always lands in active.
// R22: only pin interrupt, comparator or reset leave hibernate.
// R23: hibernate prevent bit turns hibernate requests into sleep.
// R24: distinct mode codes, 0 is active.
// R25: lower mode requests accepted only from active.
// R26: sleep and hibernate entered only by firmware write.
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
`define PMC_CODE_ACTIVE    3'h0
`define PMC_CODE_AUTO_ALT  3'h1
`define PMC_CODE_ALT       3'h2
`define PMC_CODE_SLEEP     3'h3
`define PMC_CODE_HIB       3'h4
`define PMC_TEMPLATE_REGS  14
`define PMC_CLK_HZ         10000000
`define PMC_BOOT_HOLD_US   1000
`define PMC_BUZZ_ON_CYC    16'h0004
`define PMC_BUZZ_PERIOD    16'h0400
`define PMC_ALT_DWELL      16'h0008
`endif

// ===== design/pmc_buzz.v
// periodic regulator buzz pulse generator for sleep mode
`timescale 1ns/1ps
`include "pmc_defs.vh"
module pmc_buzz #(
   parameter PERIOD = `PMC_BUZZ_PERIOD,
   parameter ON_CYC = `PMC_BUZZ_ON_CYC
) (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        run_in,
   input  wire        tick_in,
   output reg         buzz_out
);
   reg [15:0] count;
   // count slow ticks and hold the regulators on for a short window
   always @(posedge clk_in) begin
      if (rst_in || !run_in) begin
         count    <= 16'h0000;
         buzz_out <= 1'b0;
      end else if (tick_in) begin
         if (count >= PERIOD - 16'h0001) begin
            count <= 16'h0000;
         end else begin
            count <= count + 16'h0001;
         end
         buzz_out <= (count < ON_CYC); // R17
      end
   end
endmodule // pmc_buzz

// ===== design/pmc_top.v
// global power mode controller
`timescale 1ns/1ps
`include "pmc_defs.vh"
module pmc_top #(
   parameter NREG      = `PMC_TEMPLATE_REGS,
   parameter BOOT_HOLD = (`PMC_CLK_HZ / 1000) * `PMC_BOOT_HOLD_US / 1000,
   parameter ALT_DWELL = `PMC_ALT_DWELL
) (
   input  wire              clk_in,
   input  wire              rst_in,
   input  wire [2:0]        power_mode_select_in,
   input  wire              power_mode_write_in,
   input  wire              flash_ctrl_idle_in,
   input  wire [NREG*8-1:0] active_template_in,
   input  wire [NREG*8-1:0] alt_active_template_in,
   input  wire [NREG*8-1:0] subsystem_available_mask_in,
   input  wire              cpu_template_bit_in,
   input  wire              alt_cpu_template_bit_in,
   input  wire              hibernate_prevent_cfg_in,
   input  wire              wakeup_pending_in,
   input  wire              pin_interrupt_unit_wake_in,
   input  wire              comparator_wake_in,
   input  wire              other_wake_in,
   input  wire              interrupt_in,
   input  wire              low_speed_osc_in,
   input  wire              main_osc_in,
   output reg  [2:0]        mode_out,
   output reg  [NREG*8-1:0] subsystem_enable_out,
   output reg               cpu_enable_out,
   output reg               regulators_on_out,
   output wire              regulator_buzz_out,
   output reg               hibernate_reg_only_out,
   output reg               request_refused_out
);
   localparam S_ACT   = 6'b000001;
   localparam S_AUTOA = 6'b000010;
   localparam S_AUTOB = 6'b000100;
   localparam S_ALT   = 6'b001000;
   localparam S_SLEEP = 6'b010000;
   localparam S_HIB   = 6'b100000;

   reg [5:0]  state;
   reg [5:0]  next_state;
   reg [1:0]  sync_pin;
   reg [1:0]  sync_cmp;
   reg [1:0]  sync_oth;
   reg [1:0]  sync_irq;
   reg [1:0]  sync_lso;
   reg [1:0]  sync_mo;
   reg        lso_prev;
   reg [31:0] boot_count;
   reg        boot_done;
   reg        cpu_force;
   reg [15:0] dwell;
   wire       lso_tick;
   wire       pin_w;
   wire       cmp_w;
   wire       any_wake;
   wire       irq;
   wire       alt_time;
   wire       low_req;

   // pins from other domains pass two flip-flops
   always @(posedge clk_in) begin
      if (rst_in) begin
         sync_pin <= 2'h0;
         sync_cmp <= 2'h0;
         sync_oth <= 2'h0;
         sync_irq <= 2'h0;
         sync_lso <= 2'h0;
         sync_mo  <= 2'h0;
         lso_prev <= 1'b0;
      end else begin
         sync_pin <= {sync_pin[0], pin_interrupt_unit_wake_in};
         sync_cmp <= {sync_cmp[0], comparator_wake_in};
         sync_oth <= {sync_oth[0], other_wake_in};
         sync_irq <= {sync_irq[0], interrupt_in};
         sync_lso <= {sync_lso[0], low_speed_osc_in};
         sync_mo  <= {sync_mo[0], main_osc_in};
         lso_prev <= sync_lso[1];
      end
   end

   assign pin_w    = sync_pin[1];
   assign cmp_w    = sync_cmp[1];
   assign irq      = sync_irq[1];
   assign any_wake = pin_w | cmp_w | sync_oth[1];
   assign lso_tick = sync_lso[1] & ~lso_prev;
   assign alt_time = (dwell >= ALT_DWELL) & sync_mo[1]; // R02
   assign low_req  = power_mode_write_in & (power_mode_select_in != `PMC_CODE_ACTIVE);

   // ignore sleep/hibernate entry shortly after reset
   always @(posedge clk_in) begin
      if (rst_in) begin
         boot_count <= 32'h0;
         boot_done  <= 1'b0;
      end else if (!boot_done) begin
         boot_count <= boot_count + 32'h1;
         boot_done  <= (boot_count >= BOOT_HOLD - 1); // R20
      end
   end

   // next mode decision
   always @* begin
      next_state = state;
      case (state)
         S_ACT: begin
            if (low_req && !wakeup_pending_in && !any_wake) begin // R14 R25 R26
               if (power_mode_select_in == `PMC_CODE_AUTO_ALT) begin
                  next_state = S_AUTOA;
               end else if (power_mode_select_in == `PMC_CODE_ALT) begin
                  next_state = S_ALT; // R12
               end else if (power_mode_select_in == `PMC_CODE_SLEEP && boot_done) begin
                  next_state = S_SLEEP; // R20
               end else if (power_mode_select_in == `PMC_CODE_HIB && boot_done) begin
                  next_state = hibernate_prevent_cfg_in ? S_SLEEP : S_HIB; // R23
               end
            end
         end
         S_AUTOA: begin
            if (any_wake || (power_mode_write_in && power_mode_select_in == `PMC_CODE_ACTIVE)) begin
               next_state = S_ACT;
            end else if (alt_time) begin
               next_state = S_AUTOB; // R02
            end
         end
         S_AUTOB: begin
            if (any_wake || irq || (power_mode_write_in && power_mode_select_in == `PMC_CODE_ACTIVE)) begin
               next_state = S_ACT;
            end else if (alt_time) begin
               next_state = S_AUTOA; // R02
            end
         end
         S_ALT: begin
            if (any_wake || irq || power_mode_write_in) begin
               next_state = S_ACT; // R09 R16
            end
         end
         S_SLEEP: begin
            if (any_wake) begin
               next_state = S_ACT; // R21
            end
         end
         S_HIB: begin
            if (pin_w || cmp_w) begin
               next_state = S_ACT; // R22 R21
            end
         end
         default: begin
            next_state = S_ACT;
         end
      endcase
   end

   // mode register and cpu wake forcing
   // cpu is forced on after reset or a return to active until firmware sets its template bit;
   // clearing the bit after that stops the cpu
   always @(posedge clk_in) begin
      if (rst_in) begin
         state     <= S_ACT; // R09 R11
         cpu_force <= 1'b1;
         dwell     <= 16'h0000;
      end else begin
         state <= next_state;
         if (state != S_ACT && next_state == S_ACT) begin
            cpu_force <= 1'b1; // R08 R10
         end else if (state == S_ACT && cpu_template_bit_in) begin
            cpu_force <= 1'b0; // R07
         end
         if (state != next_state) begin
            dwell <= 16'h0000;
         end else if (lso_tick && dwell != 16'hffff) begin
            dwell <= dwell + 16'h0001;
         end
      end
   end

   // subsystem enables and regulator controls from the mode
   always @(posedge clk_in) begin
      if (rst_in) begin
         mode_out               <= `PMC_CODE_ACTIVE;
         subsystem_enable_out   <= {NREG*8{1'b0}};
         cpu_enable_out         <= 1'b1;
         regulators_on_out      <= 1'b1;
         hibernate_reg_only_out <= 1'b0;
         request_refused_out    <= 1'b0;
      end else begin
         request_refused_out <= power_mode_write_in && (next_state == state) && state == S_ACT && low_req;
         case (state)
            S_ACT, S_AUTOA: begin
               mode_out             <= (state == S_ACT) ? `PMC_CODE_ACTIVE : `PMC_CODE_AUTO_ALT;
               subsystem_enable_out <= active_template_in & subsystem_available_mask_in; // R04 R05 R06
               cpu_enable_out       <= cpu_template_bit_in | cpu_force; // R07 R08
               regulators_on_out    <= 1'b1;
               hibernate_reg_only_out <= 1'b0;
            end
            S_ALT, S_AUTOB: begin
               mode_out             <= (state == S_ALT) ? `PMC_CODE_ALT : `PMC_CODE_AUTO_ALT;
               subsystem_enable_out <= alt_active_template_in & subsystem_available_mask_in; // R15
               cpu_enable_out       <= alt_cpu_template_bit_in;
               regulators_on_out    <= 1'b1;
               hibernate_reg_only_out <= 1'b0;
            end
            S_SLEEP: begin
               mode_out             <= `PMC_CODE_SLEEP;
               subsystem_enable_out <= {NREG*8{1'b0}}; // R03
               cpu_enable_out       <= 1'b0;
               regulators_on_out    <= 1'b0; // R17
               hibernate_reg_only_out <= 1'b0;
            end
            default: begin
               mode_out             <= `PMC_CODE_HIB;
               subsystem_enable_out <= {NREG*8{1'b0}}; // R03
               cpu_enable_out       <= 1'b0;
               regulators_on_out    <= 1'b0;
               hibernate_reg_only_out <= 1'b1; // R18
            end
         endcase
      end
   end

   // buzz the regulators while sleeping
   pmc_buzz #(
      .PERIOD (`PMC_BUZZ_PERIOD),
      .ON_CYC (`PMC_BUZZ_ON_CYC)
   ) u_buzz (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .run_in   (state == S_SLEEP),
      .tick_in  (lso_tick),
      .buzz_out (regulator_buzz_out)
   );
endmodule // pmc_top

// ===== testbench/pmc_top_asserts.sv
// port checks for the power mode controller
`timescale 1ns/1ps
module pmc_top_asserts #(
   parameter NREG      = 14,
   parameter BOOT_HOLD = 20
) (
   input wire              clk_in,
   input wire              rst_in,
   input wire [2:0]        power_mode_select_in,
   input wire              power_mode_write_in,
   input wire              hibernate_prevent_cfg_in,
   input wire              wakeup_pending_in,
   input wire              interrupt_in,
   input wire [NREG*8-1:0] subsystem_available_mask_in,
   input wire [2:0]        mode_out,
   input wire [NREG*8-1:0] subsystem_enable_out,
   input wire              cpu_enable_out,
   input wire              request_refused_out
);
   reg  [15:0] boot_cnt;
   wire        ready = boot_cnt > BOOT_HOLD + 3;
   // cycles since reset release, saturating
   always @(posedge clk_in) begin
      if (rst_in)
         boot_cnt <= 16'h0000;
      else if (boot_cnt != 16'hffff)
         boot_cnt <= boot_cnt + 16'h0001;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // a write seen in active mode that is not the second of a back-to-back pair
   sequence s_write;
      power_mode_write_in && mode_out == 3'h0 && !wakeup_pending_in && !$past(power_mode_write_in);
   endsequence
   sequence s_back_active;
      ##[1:5] (mode_out == 3'h0 && cpu_enable_out);
   endsequence
   a_reset_to_active: assert property (disable iff (1'b0) rst_in |=> mode_out == 3'h0 && cpu_enable_out)
      else $error("mode not active after reset");
   a_low_all_off: assert property (mode_out inside {3'h3, 3'h4} |-> subsystem_enable_out == 0)
      else $error("subsystem on in a low mode");
   a_sleep_entry: assert property (s_write ##0 (power_mode_select_in == 3'h3 && ready) |-> ##2 mode_out == 3'h3)
      else $error("sleep request not taken");
   a_boot_ignore: assert property (s_write ##0 (power_mode_select_in inside {3'h3, 3'h4}
      && boot_cnt + 3 < BOOT_HOLD) |-> ##2 mode_out == 3'h0)
      else $error("low mode entered during boot hold");
   a_pending_refused: assert property (power_mode_write_in && wakeup_pending_in && mode_out == 3'h0
      && !$past(power_mode_write_in) |-> ##[1:2] request_refused_out)
      else $error("request with pending wake not refused");
   a_prevent_sleep: assert property (s_write ##0 (power_mode_select_in == 3'h4
      && hibernate_prevent_cfg_in && ready) |-> ##2 mode_out == 3'h3)
      else $error("prevented hibernate not turned to sleep");
   a_alt_irq_back: assert property (mode_out == 3'h2 && interrupt_in |-> s_back_active)
      else $error("interrupt in alternative active ignored");
   a_wake_repower: assert property (mode_out == 3'h0 && $past(mode_out) inside {3'h3, 3'h4}
      |-> (subsystem_enable_out & ~subsystem_available_mask_in) == 0 && cpu_enable_out)
      else $error("bad enables after wake");
endmodule // pmc_top_asserts
bind pmc_top pmc_top_asserts #(.NREG(NREG), .BOOT_HOLD(BOOT_HOLD)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
   .power_mode_select_in(power_mode_select_in), .power_mode_write_in(power_mode_write_in),
   .hibernate_prevent_cfg_in(hibernate_prevent_cfg_in), .wakeup_pending_in(wakeup_pending_in),
   .interrupt_in(interrupt_in), .subsystem_available_mask_in(subsystem_available_mask_in), .mode_out(mode_out),
   .subsystem_enable_out(subsystem_enable_out), .cpu_enable_out(cpu_enable_out),
   .request_refused_out(request_refused_out));

// ===== testbench/pmc_wake_model.sv
// wakeup sources and interrupt controller facing the power mode controller
`timescale 1ns/1ps
module pmc_wake_model (
   input  wire       clk_in,
   input  wire       fire_in,
   input  wire [1:0] kind_in,
   output wire       pin_wake_out,
   output wire       comp_wake_out,
   output wire       other_wake_out,
   output wire       irq_out,
   output reg        slow_osc_out,
   output reg        main_osc_out
);
   reg [2:0] hold;
   reg [1:0] kind;
   reg [4:0] div;
   initial begin
      {hold, kind, div, slow_osc_out, main_osc_out} = 12'h000;
   end
   // a fired source stays high 6 cycles, then drops to its pulled-down idle level
   always @(posedge clk_in) begin
      kind <= fire_in ? kind_in : kind;
      hold <= fire_in ? 3'h6 : ((hold != 3'h0) ? hold - 3'h1 : hold);
      div <= div + 5'h01;
      main_osc_out <= ~main_osc_out;
      slow_osc_out <= (div == 5'h1f) ? ~slow_osc_out : slow_osc_out;
   end
   // levels go straight to the controller with no edge detect; every source also interrupts
   assign pin_wake_out   = hold != 3'h0 && kind == 2'h0;
   assign comp_wake_out  = hold != 3'h0 && kind == 2'h1;
   assign other_wake_out = hold != 3'h0 && kind == 2'h2;
   assign irq_out        = hold != 3'h0;
endmodule // pmc_wake_model

// ===== testbench/pmc_top_tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`include "pmc_defs.vh"
module pmc_top_tb;
   localparam N = `PMC_TEMPLATE_REGS * 8;
   reg          clk_in, rst_in, wr, prev, cpu_t, alt_cpu_t, fire, pend, idle;
   reg  [2:0]   sel;
   reg  [1:0]   kind;
   reg  [N-1:0] act_t, alt_t, avail;
   wire [2:0]   mode;
   wire [N-1:0] en;
   wire         cpu, pin_w, cmp_w, oth_w, irq, slow, fast, regs_on, buzz, hib_only;
   integer      err_count, num_checks, seed, exp_mode, i;
   pmc_top #(.BOOT_HOLD(20)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .power_mode_select_in(sel),
      .power_mode_write_in(wr), .flash_ctrl_idle_in(idle), .active_template_in(act_t), .alt_active_template_in(alt_t),
      .subsystem_available_mask_in(avail), .cpu_template_bit_in(cpu_t), .alt_cpu_template_bit_in(alt_cpu_t),
      .hibernate_prevent_cfg_in(prev), .wakeup_pending_in(pend), .pin_interrupt_unit_wake_in(pin_w),
      .comparator_wake_in(cmp_w), .other_wake_in(oth_w), .interrupt_in(irq), .low_speed_osc_in(slow),
      .main_osc_in(fast), .mode_out(mode), .subsystem_enable_out(en), .cpu_enable_out(cpu),
      .regulators_on_out(regs_on), .regulator_buzz_out(buzz), .hibernate_reg_only_out(hib_only),
      .request_refused_out());
   pmc_wake_model u_wake (.clk_in(clk_in), .fire_in(fire), .kind_in(kind), .pin_wake_out(pin_w),
      .comp_wake_out(cmp_w), .other_wake_out(oth_w), .irq_out(irq), .slow_osc_out(slow), .main_osc_out(fast));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task check(input [127:0] seen, input [127:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr_mode(input [2:0] code);
      begin
         @(posedge clk_in);
         sel <= code;
         wr <= 1'b1;
         @(posedge clk_in);
         wr <= 1'b0;
         repeat (4) @(posedge clk_in);
         #1;
      end
   endtask
   task wake(input [1:0] k);
      begin
         @(posedge clk_in);
         kind <= k;
         fire <= 1'b1;
         @(posedge clk_in);
         fire <= 1'b0;
         repeat (14) @(posedge clk_in);
         #1;
      end
   endtask
   // new random templates and mask, cpu template bit cleared
   task shuffle;
      reg [127:0] r;
      begin
         @(posedge clk_in);
         r = {$random(seed), $random(seed), $random(seed), $random(seed)};
         act_t <= r[N-1:0];
         alt_t <= ~r[N-1:0];
         avail <= r[127:128-N];
         alt_cpu_t <= r[0];
         cpu_t <= 1'b0;
         prev <= (i == 1);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // watchdog well past the expected run of some 1600 cycles
   initial begin
      #(100 * 5000);
      err_count = err_count + 1;
      give_verdict;
   end
   // main sequence
   initial begin
      seed = 32'h317c4234;
      err_count = 0;
      num_checks = 0;
      rst_in = 1'b1;
      idle = 1'b1;
      {wr, prev, cpu_t, alt_cpu_t, fire, pend, sel, kind} = 11'h000;
      {act_t, alt_t, avail} = 0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      exp_mode = `PMC_CODE_ACTIVE;
      wr_mode(`PMC_CODE_SLEEP);
      check(mode, exp_mode);
      check(cpu, 1'b1);
      repeat (30) @(posedge clk_in) pend <= 1'b1;
      wr_mode(`PMC_CODE_SLEEP);
      check(mode, exp_mode);
      @(posedge clk_in) pend <= 1'b0;
      cpu_t <= 1'b1;
      repeat (4) @(posedge clk_in);
      cpu_t <= 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      check(cpu, 1'b0);
      $display("boot and pending tests done");
      for (i = 0; i < 3; i = i + 1) begin
         shuffle;
         wr_mode((i == 0) ? `PMC_CODE_SLEEP : `PMC_CODE_HIB);
         exp_mode = (i == 2) ? `PMC_CODE_HIB : `PMC_CODE_SLEEP;
         check(mode, exp_mode);
         check(en, 0);
         check(regs_on, 1'b0);
         check(hib_only, exp_mode == `PMC_CODE_HIB);
         wr_mode(`PMC_CODE_ACTIVE);
         check(mode, exp_mode);
         repeat (64) @(posedge clk_in);
         #1;
         check(buzz, exp_mode == `PMC_CODE_SLEEP);
         wake((i == 1) ? 2'h0 : 2'h2);
         if (i == 2) begin
            check(mode, exp_mode);
            wake(2'h1);
         end
         exp_mode = `PMC_CODE_ACTIVE;
         check(mode, exp_mode);
         check(en, act_t & avail);
         check(cpu, 1'b1);
         $display("low mode test %0d done", i);
      end
      for (i = 0; i < 2; i = i + 1) begin
         shuffle;
         wr_mode(`PMC_CODE_ALT);
         check(mode, `PMC_CODE_ALT);
         check(en, alt_t & avail);
         check(cpu, alt_cpu_t);
         if (i == 0)
            wr_mode(`PMC_CODE_ACTIVE);
         else
            wake(2'h3);
         check(mode, `PMC_CODE_ACTIVE);
         check(cpu, 1'b1);
         $display("alternative active test %0d done", i);
      end
      wr_mode(`PMC_CODE_AUTO_ALT);
      check(en, act_t & avail);
      repeat (700) @(posedge clk_in);
      #1;
      check(mode, `PMC_CODE_AUTO_ALT);
      check(en, alt_t & avail);
      repeat (500) @(posedge clk_in);
      #1;
      check(en, act_t & avail);
      check(mode == `PMC_CODE_SLEEP || mode == `PMC_CODE_HIB, 1'b0);
      wr_mode(`PMC_CODE_ACTIVE);
      check(mode, `PMC_CODE_ACTIVE);
      $display("auto alternating test done");
      give_verdict;
   end
endmodule // pmc_top_tb
